/* File: core/lcr_pin_cell.sv */
`timescale 1ns/100ps
module lcr_pin_cell (
    input wire logic mclk,
    input wire logic srst,
    input wire logic [1:0] cfg,
    input wire logic pin_in,
    output logic level_q,
    output logic pin_out_q,
    output logic pin_oe_q
);
    logic meta_q;
    logic sync_q;
    wire logic invert = (cfg == lcr_pkg::PIN_IN_INV);

    // two-stage synchroniser; only sync_q reads meta_q
    always_ff @(posedge mclk) begin
        if (srst) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
        end else begin
            meta_q <= pin_in;
            sync_q <= meta_q;
        end
    end

    // internal level after polarity, and drive of the pin
    always_ff @(posedge mclk) begin
        if (srst) begin
            level_q <= 1'b0;
            pin_out_q <= 1'b0;
            pin_oe_q <= 1'b0;
        end else begin
            level_q <= sync_q ^ invert;
            pin_out_q <= cfg[0];
            pin_oe_q <= cfg[1];
        end
    end
endmodule : lcr_pin_cell

/* File: core/lcr_pkg.sv */
package lcr_pkg;

    // register byte offsets
    localparam logic [7:0] OFF_PIN_CFG = 8'h04;
    localparam logic [7:0] OFF_LT1 = 8'h08;
    localparam logic [7:0] OFF_LT2 = 8'h0c;
    localparam logic [7:0] OFF_GIS = 8'h10;

    // reset values
    localparam logic [31:0] PIN_CFG_RST = 32'h0000_0000;
    localparam logic [31:0] LT1_RST = 32'h2121_2020;
    localparam logic [31:0] LT2_RST = 32'h0120_02f0;
    localparam logic [31:0] GIS_CTL_RST = 32'h0080_0000;

    // writable bits, from the host and from the loader
    localparam logic [31:0] PIN_CFG_WMASK = 32'h0000_00ff;
    localparam logic [31:0] LT1_WMASK = 32'hffff_ffff;
    localparam logic [31:0] LT2_PCI_WMASK = 32'he000_ffff;
    localparam logic [31:0] LT2_EE_WMASK = 32'he770_ffff;
    localparam logic [31:0] GIS_WMASK = 32'h00ac_0000;

    // pin configuration field positions
    localparam int CFG_PIN0_LSB = 0;
    localparam int CFG_PIN1_LSB = 2;
    localparam int CFG_WAKE0 = 4;
    localparam int CFG_WAKE1 = 5;
    localparam int CFG_PD0 = 6;
    localparam int CFG_PD1 = 7;

    // window size fields in the second timing register
    localparam int LT2_BAR0_LSB = 20;
    localparam int LT2_BAR1_LSB = 24;

    // interrupt status and control bit positions
    localparam int GIS_PIN0 = 2;
    localparam int GIS_PIN1 = 3;
    localparam int GIS_IEN0 = 18;
    localparam int GIS_IEN1 = 19;
    localparam int GIS_PD_FLAG = 20;
    localparam int GIS_PD_IEN = 21;
    localparam int GIS_PP_STAT = 22;
    localparam int GIS_PP_IEN = 23;

    // pin modes
    localparam logic [1:0] PIN_IN = 2'h0;
    localparam logic [1:0] PIN_IN_INV = 2'h1;
    localparam logic [1:0] PIN_OUT_LO = 2'h2;
    localparam logic [1:0] PIN_OUT_HI = 2'h3;

    // local bus sequencing
    localparam logic [1:0] REF_CYCLES = 2'h2;
    localparam logic [3:0] TIMING_MAX = 4'ha;

    typedef struct packed {
        logic [3:0] wr_deassert;
        logic [3:0] wr_assert;
        logic [3:0] rd_deassert;
        logic [3:0] rd_assert;
        logic [3:0] wr_end;
        logic [3:0] wr_start;
        logic [3:0] rd_end;
        logic [3:0] rd_start;
    } lcr_timing_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [3:0] be;
        logic [31:0] wdata;
    } lcr_req_t;

    typedef enum logic [1:0] {
        LCR_IDLE = 2'b00,
        LCR_REF = 2'b01,
        LCR_RUN = 2'b10
    } lcr_seq_t;

endpackage : lcr_pkg

/* File: core/lcr_regs.sv */
// How it works
// - pin 0 mode: input, inverted, drive low/high
// - pin 1 same four modes at bits 3:2
// - bit 4 lets pin 0 set wake flag
// - bit 5 lets pin 1 set wake flag
// - bits 6,7 route pins to power-down filter
// - eight 4-bit local bus timing fields
// - timings count cycles after reference cycle
// - window size zero, read-only, loader writable
// - window size one, reset 001, read-only, loader writable
// - status bits 2,3 show internal pin levels
// - bits 18,19 enable pin interrupts
// - power-down flag sticky, cleared on read
// - bit 21 enables power-down interrupt
// - bit 22 shows parallel port interrupt
// - bit 23 enables parallel port interrupt, reset one
// - power-down level is inverse of interrupt level
// - interrupt is a shared level output
// - wake flag sticky, cleared by writing one
`timescale 1ns/100ps
module lcr_regs (
    input wire logic mclk,
    input wire logic srst,
    input wire lcr_pkg::lcr_req_t req,
    input wire logic ee_wr,
    input wire logic [7:0] ee_addr,
    input wire logic [31:0] ee_wdata,
    input wire logic [1:0] mio_in,
    input wire logic pd_request,
    input wire logic pp_irq,
    input wire logic pme_en,
    input wire logic wake_clr,
    input wire logic lb_irdy,
    input wire logic lb_is_write,
    output logic [31:0] rd_data_q,
    output logic rd_valid_q,
    output logic [1:0] mio_out_q,
    output logic [1:0] mio_oe_q,
    output logic inta_oe_q,
    output logic wake_oe_q,
    output logic wake_status_flag_q,
    output logic pd_filter_in_q,
    output lcr_pkg::lcr_timing_t timing_q,
    output logic [2:0] bar0_size_q,
    output logic [2:0] bar1_size_q,
    output logic lb_cs_q,
    output logic lb_rd_q,
    output logic lb_wr_q
);
    logic [31:0] cfg_q;
    logic [31:0] lt2_q;
    logic [31:0] gis_ctl_q;
    logic pd_flag_q;
    logic [1:0] level_prev_q;
    lcr_pkg::lcr_seq_t seq_q;
    lcr_pkg::lcr_seq_t seq_d;
    logic [1:0] ref_cnt_q;
    logic [3:0] phase_q;
    logic is_wr_q;
    logic [1:0] level;

    // one cell per multi-purpose pin
    // each cell registers its level, so status lags the pin by three clocks
    lcr_pin_cell u_pin0 (
        .mclk(mclk),
        .srst(srst),
        .cfg(cfg_q[lcr_pkg::CFG_PIN0_LSB +: 2]),
        .pin_in(mio_in[0]),
        .level_q(level[0]),
        .pin_out_q(mio_out_q[0]),
        .pin_oe_q(mio_oe_q[0])
    );

    lcr_pin_cell u_pin1 (
        .mclk(mclk),
        .srst(srst),
        .cfg(cfg_q[lcr_pkg::CFG_PIN1_LSB +: 2]),
        .pin_in(mio_in[1]),
        .level_q(level[1]),
        .pin_out_q(mio_out_q[1]),
        .pin_oe_q(mio_oe_q[1])
    );

    // byte-lane write mask and address decode
    wire logic [31:0] lane_mask = {{8{req.be[3]}}, {8{req.be[2]}}, {8{req.be[1]}},
                                   {8{req.be[0]}}};
    wire logic hit_cfg = req.addr == lcr_pkg::OFF_PIN_CFG;
    wire logic hit_lt1 = req.addr == lcr_pkg::OFF_LT1;
    wire logic hit_lt2 = req.addr == lcr_pkg::OFF_LT2;
    wire logic hit_gis = req.addr == lcr_pkg::OFF_GIS;
    wire logic ee_cfg = ee_wr && (ee_addr == lcr_pkg::OFF_PIN_CFG);
    wire logic ee_lt1 = ee_wr && (ee_addr == lcr_pkg::OFF_LT1);
    wire logic ee_lt2 = ee_wr && (ee_addr == lcr_pkg::OFF_LT2);
    wire logic ee_gis = ee_wr && (ee_addr == lcr_pkg::OFF_GIS);
    // host write strobes, one per register
    wire logic wr_cfg = req.wr && hit_cfg;
    wire logic wr_lt1 = req.wr && hit_lt1;
    wire logic wr_lt2 = req.wr && hit_lt2;
    wire logic wr_gis = req.wr && hit_gis;

    // host write merges: only writable bits in enabled lanes change
    wire logic [31:0] m_cfg = lane_mask & lcr_pkg::PIN_CFG_WMASK;
    wire logic [31:0] m_lt1 = lane_mask & lcr_pkg::LT1_WMASK;
    wire logic [31:0] m_lt2 = lane_mask & lcr_pkg::LT2_PCI_WMASK;
    wire logic [31:0] m_gis = lane_mask & lcr_pkg::GIS_WMASK;
    wire logic [31:0] cfg_pci = (cfg_q & ~m_cfg) | (req.wdata & m_cfg);
    wire logic [31:0] lt1_pci = (timing_q & ~m_lt1) | (req.wdata & m_lt1);
    wire logic [31:0] lt2_pci = (lt2_q & ~m_lt2) | (req.wdata & m_lt2);
    wire logic [31:0] gis_pci = (gis_ctl_q & ~m_gis) | (req.wdata & m_gis);

    // loader writes whole words and may also set the window sizes
    wire logic [31:0] cfg_ee = ee_wdata & lcr_pkg::PIN_CFG_WMASK;
    wire logic [31:0] lt1_ee = ee_wdata & lcr_pkg::LT1_WMASK;
    wire logic [31:0] lt2_ee = (lt2_q & ~lcr_pkg::LT2_EE_WMASK) |
                               (ee_wdata & lcr_pkg::LT2_EE_WMASK);
    wire logic [31:0] gis_ee = ee_wdata & lcr_pkg::GIS_WMASK;

    // next words; the loader wins a same-cycle collision, as it only runs
    // after reset and its preset must not be half overwritten
    wire logic [31:0] cfg_d = ee_cfg ? cfg_ee : wr_cfg ? cfg_pci : cfg_q;
    wire logic [31:0] lt1_d = ee_lt1 ? lt1_ee : wr_lt1 ? lt1_pci : timing_q;
    wire logic [31:0] lt2_d = ee_lt2 ? lt2_ee : wr_lt2 ? lt2_pci : lt2_q;
    wire logic [31:0] gis_ctl_d = ee_gis ? gis_ee : wr_gis ? gis_pci : gis_ctl_q;

    // configuration storage
    always_ff @(posedge mclk) begin
        if (srst) begin
            cfg_q <= lcr_pkg::PIN_CFG_RST;
            timing_q <= lcr_pkg::LT1_RST;
            lt2_q <= lcr_pkg::LT2_RST;
            gis_ctl_q <= lcr_pkg::GIS_CTL_RST;
        end else begin
            cfg_q <= cfg_d;
            timing_q <= lt1_d;
            lt2_q <= lt2_d;
            gis_ctl_q <= gis_ctl_d;
        end
    end

    // window sizes brought out for the base address logic
    // a registered copy keeps the address decode off the write path
    always_ff @(posedge mclk) begin
        if (srst) begin
            bar0_size_q <= lcr_pkg::LT2_RST[lcr_pkg::LT2_BAR0_LSB +: 3];
            bar1_size_q <= lcr_pkg::LT2_RST[lcr_pkg::LT2_BAR1_LSB +: 3];
        end else begin
            bar0_size_q <= lt2_q[lcr_pkg::LT2_BAR0_LSB +: 3];
            bar1_size_q <= lt2_q[lcr_pkg::LT2_BAR1_LSB +: 3];
        end
    end

    // interrupt status word; reserved bits read zero
    wire logic [31:0] gis_view = gis_ctl_q |
                                 (32'(level[0]) << lcr_pkg::GIS_PIN0) |
                                 (32'(level[1]) << lcr_pkg::GIS_PIN1) |
                                 (32'(pd_flag_q) << lcr_pkg::GIS_PD_FLAG) |
                                 (32'(pp_irq) << lcr_pkg::GIS_PP_STAT);
    wire logic [31:0] rd_mux = hit_cfg ? cfg_q :
                               hit_lt1 ? timing_q :
                               hit_lt2 ? lt2_q :
                               hit_gis ? gis_view : 32'h0000_0000;

    // read answer one cycle after the request, zero when unmapped
    wire logic [31:0] rd_data_d = req.rd ? rd_mux : rd_data_q;
    always_ff @(posedge mclk) begin
        if (srst) begin
            rd_data_q <= 32'h0000_0000;
            rd_valid_q <= 1'b0;
        end else begin
            rd_data_q <= rd_data_d;
            rd_valid_q <= req.rd;
        end
    end

    // a read of lane 2 clears the flag, but a request landing then survives
    wire logic pd_rd_clr = req.rd && hit_gis && req.be[2];
    wire logic pd_flag_d = pd_request | (pd_flag_q & ~pd_rd_clr);
    always_ff @(posedge mclk) begin
        if (srst) begin
            pd_flag_q <= 1'b0;
        end else begin
            pd_flag_q <= pd_flag_d;
        end
    end

    // wake on either edge of an enabled pin; set beats software clear
    wire logic [1:0] level_edge = level ^ level_prev_q;
    wire logic wake_set = (level_edge[0] & cfg_q[lcr_pkg::CFG_WAKE0]) |
                          (level_edge[1] & cfg_q[lcr_pkg::CFG_WAKE1]);
    // next flag and wake pin values
    wire logic wake_flag_d = wake_set | (wake_status_flag_q & ~wake_clr);
    wire logic wake_oe_d = wake_status_flag_q & pme_en;
    always_ff @(posedge mclk) begin
        if (srst) begin
            level_prev_q <= 2'h0;
            wake_status_flag_q <= 1'b0;
            wake_oe_q <= 1'b0;
        end else begin
            level_prev_q <= level;
            wake_status_flag_q <= wake_flag_d;
            wake_oe_q <= wake_oe_d;
        end
    end

    // interrupt sources from the pins, the power-down flag and the parallel port, and the power-down source
    wire logic pin_irq = (level[0] & gis_ctl_q[lcr_pkg::GIS_IEN0]) |
                         (level[1] & gis_ctl_q[lcr_pkg::GIS_IEN1]);
    wire logic pd_irq = pd_flag_q & gis_ctl_q[lcr_pkg::GIS_PD_IEN];
    wire logic pp_src = pp_irq & gis_ctl_q[lcr_pkg::GIS_PP_IEN];
    // inverse of the interrupting level, so a quiet device starts power-down
    wire logic pd_src = (~level[0] & cfg_q[lcr_pkg::CFG_PD0]) |
                        (~level[1] & cfg_q[lcr_pkg::CFG_PD1]);
    // registered so the shared line never glitches while sources settle
    wire logic inta_d = pin_irq | pd_irq | pp_src;

    // open-drain interrupt: enable pulls the shared line low while any source is up
    always_ff @(posedge mclk) begin
        if (srst) begin
            inta_oe_q <= 1'b0;
            pd_filter_in_q <= 1'b0;
        end else begin
            inta_oe_q <= inta_d;
            pd_filter_in_q <= pd_src;
        end
    end

    // selected timing set for the access in flight
    wire logic [3:0] t_start = is_wr_q ? timing_q.wr_start : timing_q.rd_start;
    wire logic [3:0] t_end = is_wr_q ? timing_q.wr_end : timing_q.rd_end;
    wire logic [3:0] t_on = is_wr_q ? timing_q.wr_assert : timing_q.rd_assert;
    wire logic [3:0] t_off = is_wr_q ? timing_q.wr_deassert : timing_q.rd_deassert;
    wire logic in_run = (seq_q == lcr_pkg::LCR_RUN);
    wire logic run_done = in_run && (phase_q == lcr_pkg::TIMING_MAX);

    // counts run only in their own state; direction is latched while idle
    // fields above Ah are never met by the phase count; a start field there never raises its strobe, an end field leaves it up until the run ends
    wire logic [1:0] ref_cnt_d = (seq_q == lcr_pkg::LCR_REF) ? ref_cnt_q + 2'h1 : 2'h0;
    wire logic [3:0] phase_d = in_run ? phase_q + 4'h1 : 4'h0;
    wire logic is_wr_d = (seq_q == lcr_pkg::LCR_IDLE) ? lb_is_write : is_wr_q;

    // sequencer: wait for the reference cycle, then count off the fields
    always_comb begin
        seq_d = seq_q;
        case (seq_q)
            lcr_pkg::LCR_IDLE: begin
                if (lb_irdy) begin
                    seq_d = lcr_pkg::LCR_REF;
                end
            end
            lcr_pkg::LCR_REF: begin
                if (ref_cnt_q == lcr_pkg::REF_CYCLES - 2'h1) begin
                    seq_d = lcr_pkg::LCR_RUN;
                end
            end
            lcr_pkg::LCR_RUN: begin
                if (run_done) begin
                    seq_d = lcr_pkg::LCR_IDLE;
                end
            end
            default: begin
                seq_d = lcr_pkg::LCR_IDLE;
            end
        endcase
    end

    // sequencer state and counts
    always_ff @(posedge mclk) begin
        if (srst) begin
            seq_q <= lcr_pkg::LCR_IDLE;
            ref_cnt_q <= 2'h0;
            phase_q <= 4'h0;
            is_wr_q <= 1'b0;
        end else begin
            seq_q <= seq_d;
            ref_cnt_q <= ref_cnt_d;
            phase_q <= phase_d;
            is_wr_q <= is_wr_d;
        end
    end

    // start wins over end when both fields hold the same value
    wire logic cs_d = !in_run ? 1'b0 : (phase_q == t_start) ? 1'b1 :
                      (phase_q == t_end) ? 1'b0 : lb_cs_q;
    wire logic strb_d = !in_run ? 1'b0 : (phase_q == t_on) ? 1'b1 :
                        (phase_q == t_off) ? 1'b0 : (lb_rd_q | lb_wr_q);
    // one strobe per direction; the other stays low for the whole access
    wire logic lb_rd_d = strb_d & ~is_wr_q;
    wire logic lb_wr_d = strb_d & is_wr_q;

    always_ff @(posedge mclk) begin
        if (srst) begin
            lb_cs_q <= 1'b0;
            lb_rd_q <= 1'b0;
            lb_wr_q <= 1'b0;
        end else begin
            lb_cs_q <= cs_d;
            lb_rd_q <= lb_rd_d;
            lb_wr_q <= lb_wr_d;
        end
    end
endmodule : lcr_regs

/* File: tb/lcr_far_model.sv */
`timescale 1ns/100ps
module lcr_far_model (
    input wire logic [1:0] ext_lvl,
    input wire logic [1:0] mio_out_q,
    input wire logic [1:0] mio_oe_q,
    output logic [1:0] mio_in
);
    // wire level: the block wins where it drives, else the outside device
    assign mio_in = (mio_oe_q & mio_out_q) | (~mio_oe_q & ext_lvl);
endmodule : lcr_far_model

/* File: tb/lcr_regs_bench.sv */
`timescale 1ns/100ps
bind lcr_regs lcr_regs_props lcr_regs_props_i (.mclk(mclk), .srst(srst), .req(req),
    .ee_wr(ee_wr), .pp_irq(pp_irq), .pme_en(pme_en), .rd_data_q(rd_data_q),
    .rd_valid_q(rd_valid_q), .mio_out_q(mio_out_q), .mio_oe_q(mio_oe_q),
    .wake_oe_q(wake_oe_q), .wake_status_flag_q(wake_status_flag_q),
    .timing_q(timing_q), .bar0_size_q(bar0_size_q), .bar1_size_q(bar1_size_q));
module lcr_regs_bench;
    logic mclk = 1'b0;
    logic srst = 1'b1;
    lcr_pkg::lcr_req_t req = '0;
    logic ee_wr = 1'b0;
    logic [7:0] ee_addr = 8'h0;
    logic [31:0] ee_wdata = 32'h0;
    logic [1:0] ext_lvl = 2'b11;
    logic [1:0] mio_in;
    logic pd_request = 1'b0;
    logic pp_irq = 1'b0;
    logic pme_en = 1'b0;
    logic wake_clr = 1'b0;
    logic lb_irdy = 1'b0;
    logic lb_is_write = 1'b0;
    logic [31:0] rd_data_q;
    logic rd_valid_q, inta_oe_q, wake_oe_q, wake_status_flag_q, pd_filter_in_q;
    logic [1:0] mio_out_q, mio_oe_q;
    lcr_pkg::lcr_timing_t timing_q;
    logic [2:0] bar0_size_q, bar1_size_q;
    logic lb_cs_q, lb_rd_q, lb_wr_q, lvl;
    int n_fail = 0;
    int compares = 0;
    // 20 MHz clock
    always #25 mclk = ~mclk;
    lcr_regs lcr_regs_i (.mclk(mclk), .srst(srst), .req(req), .ee_wr(ee_wr),
        .ee_addr(ee_addr), .ee_wdata(ee_wdata), .mio_in(mio_in), .pd_request(pd_request),
        .pp_irq(pp_irq), .pme_en(pme_en), .wake_clr(wake_clr), .lb_irdy(lb_irdy),
        .lb_is_write(lb_is_write), .rd_data_q(rd_data_q), .rd_valid_q(rd_valid_q),
        .mio_out_q(mio_out_q), .mio_oe_q(mio_oe_q), .inta_oe_q(inta_oe_q),
        .wake_oe_q(wake_oe_q), .wake_status_flag_q(wake_status_flag_q),
        .pd_filter_in_q(pd_filter_in_q), .timing_q(timing_q), .bar0_size_q(bar0_size_q),
        .bar1_size_q(bar1_size_q), .lb_cs_q(lb_cs_q), .lb_rd_q(lb_rd_q), .lb_wr_q(lb_wr_q));
    lcr_far_model lcr_far_model_i (.ext_lvl(ext_lvl), .mio_out_q(mio_out_q),
        .mio_oe_q(mio_oe_q), .mio_in(mio_in));
    task chk(input string nm, input logic [31:0] e, input logic [31:0] got);
        compares++;
        if (got !== e) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, got);
        end
    endtask : chk
    task tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : tick
    task wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
        @(posedge mclk);
        req <= '{wr: 1'b1, rd: 1'b0, addr: a, be: be, wdata: d};
        @(posedge mclk);
        req.wr <= 1'b0;
    endtask : wr
    // data is looked at in the single cycle that valid stands
    task rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        @(posedge mclk);
        req <= '{wr: 1'b0, rd: 1'b1, addr: a, be: 4'hf, wdata: 32'h0};
        @(posedge mclk);
        req.rd <= 1'b0;
        #1;
        chk("rd_valid", 32'h1, {31'h0, rd_valid_q});
        chk("rd_data", e, rd_data_q & m);
    endtask : rd
    task wclr;
        @(posedge mclk);
        wake_clr <= 1'b1;
        @(posedge mclk);
        wake_clr <= 1'b0;
        tick(1);
        chk("wake_flag", 32'h0, {31'h0, wake_status_flag_q});
    endtask : wclr
    task pin(input logic [1:0] v, input logic e);
        @(posedge mclk);
        ext_lvl <= v;
        tick(6);
        chk("wake_flag", {31'h0, e}, {31'h0, wake_status_flag_q});
    endtask : pin
    // strobes counted from the edge that takes the idle request
    task lb_run(input logic w, input int s, input int e, input int a, input int d);
        @(posedge mclk);
        lb_irdy <= 1'b1;
        lb_is_write <= w;
        @(posedge mclk);
        lb_irdy <= 1'b0;
        for (int k = 1; k < 16; k++) begin
            tick(1);
            chk("lb_cs", {31'h0, k >= 3 + s && k < 3 + e}, {31'h0, lb_cs_q});
            chk("lb_strobe", {31'h0, k >= 3 + a && k < 3 + d}, {31'h0, w ? lb_wr_q : lb_rd_q});
            chk("lb_other", 32'h0, {31'h0, w ? lb_rd_q : lb_wr_q});
        end
    endtask : lb_run
    task results;
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : results
    // hang guard, far beyond the fewer than two hundred cycles the tests need
    initial begin
        repeat (4000) @(posedge mclk);
        n_fail++;
        results();
    end
    initial begin
        repeat (16) @(posedge mclk);
        srst <= 1'b0;
        rd(8'h04, 32'hffff_ffff, 32'h0);
        rd(8'h08, 32'hffff_ffff, 32'h2121_2020);
        rd(8'h0c, 32'hffff_ffff, 32'h0120_02f0);
        rd(8'h10, 32'hffff_ffff, 32'h0080_000c);
        rd(8'h14, 32'hffff_ffff, 32'h0);
        wr(8'h04, 4'hf, 32'hffff_ffff);
        rd(8'h04, 32'hffff_ffff, 32'h0000_00ff);
        wr(8'h0c, 4'hf, 32'h1fff_02f0);
        rd(8'h0c, 32'hffff_ffff, 32'h0120_02f0);
        wr(8'h0c, 4'hf, 32'h0120_02f0);
        @(posedge mclk);
        ee_wr <= 1'b1;
        ee_addr <= 8'h0c;
        ee_wdata <= 32'h0170_02f0;
        @(posedge mclk);
        ee_wr <= 1'b0;
        rd(8'h0c, 32'hffff_ffff, 32'h0170_02f0);
        chk("bar_sizes", 32'h0000_0017, {25'h0, bar1_size_q, 1'b0, bar0_size_q});
        wr(8'h10, 4'hf, 32'hffff_ffff);
        rd(8'h10, 32'hffff_ffff, 32'h00ac_000c);
        chk("inta", 32'h1, {31'h0, inta_oe_q});
        $display("test registers done");
        wr(8'h10, 4'hf, 32'h0004_0000);
        for (int m = 0; m < 4; m++) begin
            wr(8'h04, 4'h1, {28'h0, m[1:0], m[1:0]});
            tick(5);
            lvl = m[0] ~^ m[1];
            chk("mio_oe", {30'h0, m[1], m[1]}, {30'h0, mio_oe_q});
            chk("mio_out", {30'h0, m[0], m[0]}, {30'h0, mio_out_q});
            rd(8'h10, 32'h0000_000c, {28'h0, lvl, lvl, 2'h0});
            chk("inta", {31'h0, lvl}, {31'h0, inta_oe_q});
        end
        $display("test pins done");
        wr(8'h04, 4'h1, 32'h0000_0041);
        tick(5);
        chk("pd_filter", 32'h1, {31'h0, pd_filter_in_q});
        chk("inta", 32'h0, {31'h0, inta_oe_q});
        wr(8'h10, 4'hf, 32'h0020_0000);
        @(posedge mclk);
        pd_request <= 1'b1;
        @(posedge mclk);
        pd_request <= 1'b0;
        tick(2);
        chk("inta", 32'h1, {31'h0, inta_oe_q});
        rd(8'h10, 32'h0010_0000, 32'h0010_0000);
        rd(8'h10, 32'h0010_0000, 32'h0);
        tick(2);
        chk("inta", 32'h0, {31'h0, inta_oe_q});
        wr(8'h10, 4'hf, 32'h0);
        @(posedge mclk);
        pp_irq <= 1'b1;
        tick(2);
        chk("inta", 32'h0, {31'h0, inta_oe_q});
        wr(8'h10, 4'hf, 32'h0080_0000);
        rd(8'h10, 32'h0040_0000, 32'h0040_0000);
        chk("inta", 32'h1, {31'h0, inta_oe_q});
        @(posedge mclk);
        pp_irq <= 1'b0;
        $display("test interrupts done");
        @(posedge mclk);
        pme_en <= 1'b1;
        wr(8'h04, 4'h1, 32'h0000_0010);
        tick(5);
        wclr();
        pin(2'b10, 1'b1);
        chk("wake_oe", 32'h1, {31'h0, wake_oe_q});
        wclr();
        pin(2'b00, 1'b0);
        wr(8'h04, 4'h1, 32'h0000_0020);
        pin(2'b10, 1'b1);
        $display("test wake done");
        lb_run(1'b0, 0, 2, 1, 2);
        wr(8'h08, 4'hf, 32'h2121_a020);
        lb_run(1'b1, 0, 10, 1, 2);
        $display("test local bus done");
        results();
    end
endmodule : lcr_regs_bench

/* File: tb/lcr_regs_props.sv */
`timescale 1ns/100ps
module lcr_regs_props (
    input wire logic mclk,
    input wire logic srst,
    input wire lcr_pkg::lcr_req_t req,
    input wire logic ee_wr,
    input wire logic pp_irq,
    input wire logic pme_en,
    input wire logic [31:0] rd_data_q,
    input wire logic rd_valid_q,
    input wire logic [1:0] mio_out_q,
    input wire logic [1:0] mio_oe_q,
    input wire logic wake_oe_q,
    input wire logic wake_status_flag_q,
    input wire lcr_pkg::lcr_timing_t timing_q,
    input wire logic [2:0] bar0_size_q,
    input wire logic [2:0] bar1_size_q
);
    default clocking @(posedge mclk); endclocking
    default disable iff (srst);
    // host read of one offset; data follows one cycle later
    sequence s_rd(logic [7:0] a);
        req.rd && req.addr == a;
    endsequence
    property p_rd_valid;
        req.rd |=> rd_valid_q;
    endproperty
    property p_unmapped;
        req.rd && !(req.addr inside {8'h04, 8'h08, 8'h0c, 8'h10}) |=> rd_data_q == 32'h0;
    endproperty
    property p_cfg_rsv;
        s_rd(8'h04) |=> rd_data_q[31:8] == 24'h0;
    endproperty
    property p_lt1_rd;
        s_rd(8'h08) |=> rd_data_q == $past(timing_q);
    endproperty
    property p_lt2_rd;
        s_rd(8'h0c) |=> rd_data_q[26:16] == {$past(bar1_size_q), 1'b0, $past(bar0_size_q), 4'h0};
    endproperty
    property p_gis_rd;
        s_rd(8'h10) |=> rd_data_q[22] == $past(pp_irq) && rd_data_q[31:24] == 8'h0
            && rd_data_q[17:4] == 14'h0 && rd_data_q[1:0] == 2'h0;
    endproperty
    // loader writes win, so only plain host writes are followed
    property p_pin_mode;
        req.wr && req.addr == 8'h04 && req.be[0] && !ee_wr |-> ##2
            mio_oe_q == {$past(req.wdata[3], 2), $past(req.wdata[1], 2)}
            && mio_out_q == {$past(req.wdata[2], 2), $past(req.wdata[0], 2)};
    endproperty
    property p_wake_oe;
        1'b1 |=> wake_oe_q == ($past(wake_status_flag_q) && $past(pme_en));
    endproperty
    a_rd_valid: assert property (p_rd_valid) else $error("read not answered");
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    a_cfg_rsv: assert property (p_cfg_rsv) else $error("pin config reserved bits set");
    a_lt1_rd: assert property (p_lt1_rd) else $error("timing readback differs");
    a_lt2_rd: assert property (p_lt2_rd) else $error("window size readback wrong");
    a_gis_rd: assert property (p_gis_rd) else $error("interrupt status readback wrong");
    a_pin_mode: assert property (p_pin_mode) else $error("pin drive mismatch");
    a_wake_oe: assert property (p_wake_oe) else $error("wake pin mismatch");
endmodule : lcr_regs_props
